// ==== src/pocsf_pkg.sv ====
// How it works
// - Switch-on-fault trips at once above start
// - Breaker open when max current below 0.02
// - No trip unless breaker seen open first
// - Open source: current threshold or chosen input
// - Open must last dead-line delay before arming
// - Trip only inside active-after-closure window
// - Switch-on-fault has one settings set only
// - Stages compare largest fundamental phase current
// - Start above setting, drop below 97% of it, trip after delay
// - Three stages; first may use dependent delay
// - Zero fixed delay gives instantaneous trip
// - Dependent delay shortens as current rises
// - Current saturates at fifty times nominal
// - Harmonics option compares true RMS value
// - Harmonics option adds five ms delay
// - Each stage holds four setting groups
package pocsf_pkg;
   localparam int N_STG = 3;
   localparam int N_GRP = 4;
   localparam int N_DI = 8;
   localparam int N_VI = 8;
   localparam int N_IRQ = 7;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_NS = 32'h64;
   localparam int TICK_NS = 32'hF4240;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam int MS_PER_STEP = 32'hA;
   localparam int HARM_MS = 32'h5;
   // ----------------------------------------
   // Current levels, 0.01 x nominal units
   // ----------------------------------------
   localparam logic [15:0] LOW_LIM = 16'h0002;
   localparam logic [15:0] SAT_LIM = 16'h1388;
   localparam logic [7:0] RR_NUM = 8'h61;
   localparam logic [7:0] RR_DEN = 8'h64;
   // ----------------------------------------
   // Register offsets and fields
   // ----------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h0C;
   localparam logic [7:0] OFS_IRQ_EN = 8'h10;
   localparam logic [7:0] OFS_SF_START = 8'h14;
   localparam logic [7:0] OFS_SF_DEAD = 8'h18;
   localparam logic [7:0] OFS_SF_WIN = 8'h1C;
   localparam logic [7:0] OFS_SF_SRC = 8'h20;
   localparam int STG_BASE_BIT = 7;
   localparam int STG_DLY_BIT = 2;
   localparam int CTRL_GRP_LSB = 0;
   localparam int CTRL_DEP_BIT = 2;
   localparam int CTRL_HARM_LSB = 3;
   localparam int CTRL_EN_LSB = 5;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [15:0] RST_ST_START = 16'h0064;
   localparam logic [2:0] RST_EN = 3'h7;
   localparam logic [15:0] RST_SF_START = 16'h0064;
   localparam logic [15:0] RST_SF_WIN = 16'h000A;
   typedef enum logic [1:0] {
      SF_IDLE = 2'b00,
      SF_DEAD = 2'b01,
      SF_ARMED = 2'b10,
      SF_WIN = 2'b11
   } pocsf_sf_e;
endpackage

// ==== src/pocsf_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module pocsf_top #(
   parameter int TICK_CYCLES = pocsf_pkg::TICK_CYC
) (
   input wire logic clock_in, // 10 MHz
   input wire logic rst_n_in, // Async reset
   input wire logic enable_in, // Clock enable
   input wire logic [15:0] fund_l1_in, // Fundamental L1
   input wire logic [15:0] fund_l2_in, // Fundamental L2
   input wire logic [15:0] fund_l3_in, // Fundamental L3
   input wire logic [15:0] rms_l1_in, // True RMS L1
   input wire logic [15:0] rms_l2_in, // True RMS L2
   input wire logic [15:0] rms_l3_in, // True RMS L3
   input wire logic [7:0] digital_input_in, // Pins
   input wire logic [7:0] virtual_input_in, // Logic
   input wire logic [7:0] reg_addr_in, // Address
   input wire logic [31:0] reg_wdata_in, // Write data
   input wire logic reg_wr_in, // Write strobe
   input wire logic reg_rd_in, // Read strobe
   output logic [31:0] reg_rdata_out, // Read data
   output logic [2:0] stage_start_out, // Stage start
   output logic [2:0] stage_trip_out, // Stage trip
   output logic switch_on_fault_trip_out, // Fault trip
   output logic irq_out // Interrupt
);
   typedef struct packed {
      logic [7:0] di_s0;
      logic [7:0] di_s1;
      logic [7:0] di_s2;
      logic [7:0] di_st;
      logic [15:0] tick_cnt;
      logic [1:0] grp;
      logic dep_mode;
      logic [1:0] harm;
      logic [2:0] stg_en;
      logic [2:0][3:0][15:0] st_start;
      logic [2:0][3:0][19:0] st_delay;
      logic [2:0][31:0] st_tmr;
      logic [2:0] st_start_o;
      logic [2:0] st_trip_o;
      logic [15:0] sf_start;
      logic [15:0] sf_dead;
      logic [15:0] sf_win;
      logic [4:0] sf_src;
      pocsf_pkg::pocsf_sf_e sf_st;
      logic [23:0] sf_tmr;
      logic sf_trip;
      logic [6:0] irq_stat;
      logic [6:0] irq_en;
      logic irq;
      logic [31:0] rdata;
   } pocsf_st_s;

   pocsf_st_s q;
   pocsf_st_s d;

   // ----------------------------------------
   // Current selection
   // ----------------------------------------
   function automatic logic [15:0] pocsf_max3(input logic [15:0] a, input logic [15:0] b,
                                              input logic [15:0] c);
      logic [15:0] m;
      m = a;
      if (b > m) begin
         m = b;
      end
      if (c > m) begin
         m = c;
      end
      if (m > pocsf_pkg::SAT_LIM) begin
         m = pocsf_pkg::SAT_LIM;
      end
      return m;
   endfunction

   logic [15:0] fmax;
   logic [15:0] rmax;
   logic tick;
   logic [2:0][15:0] s_start;
   logic [2:0][15:0] s_cur;
   logic [2:0][31:0] s_tgt;
   logic [2:0][31:0] s_inc;
   logic [2:0] s_over;
   logic [2:0] s_under;
   logic [15:0] in_all;
   logic sf_open;
   logic sf_over;
   logic sf_under;
   logic [23:0] dead_ms;
   logic [23:0] win_ms;
   logic [6:0] ev;
   logic [6:0] clr;
   logic [1:0] wst;
   logic [1:0] wgp;

   assign fmax = pocsf_max3(fund_l1_in, fund_l2_in, fund_l3_in);
   assign rmax = pocsf_max3(rms_l1_in, rms_l2_in, rms_l3_in);
   assign tick = (q.tick_cnt == 16'(TICK_CYCLES - 1));
   assign wst = reg_addr_in[6:5];
   assign wgp = reg_addr_in[4:3];

   // ----------------------------------------
   // Per-stage compare and delay target
   // ----------------------------------------
   generate
      for (genvar i = 0; i < pocsf_pkg::N_STG; i++) begin : g_stg
         logic hs;
         logic dep;
         logic [31:0] base;
         assign hs = (i < 2) ? q.harm[i % 2] : 1'b0;
         assign dep = (i == 0) ? q.dep_mode : 1'b0;
         assign s_start[i] = q.st_start[i][q.grp];
         assign s_cur[i] = hs ? rmax : fmax;
         assign s_over[i] = q.stg_en[i] && (s_cur[i] > s_start[i]);
         assign s_under[i] = !q.stg_en[i]
            || (24'(s_cur[i]) * 24'(pocsf_pkg::RR_DEN)
                < 24'(s_start[i]) * 24'(pocsf_pkg::RR_NUM));
         assign base = 32'(q.st_delay[i][q.grp]) * 32'(pocsf_pkg::MS_PER_STEP)
            + (hs ? 32'(pocsf_pkg::HARM_MS) : 32'h0);
         assign s_tgt[i] = dep ? base * 32'(s_start[i]) : base;
         assign s_inc[i] = dep ? 32'(s_cur[i]) : 32'h1;
      end
   endgenerate

   // ----------------------------------------
   // Switch-on-fault conditions
   // ----------------------------------------
   assign in_all = {virtual_input_in, q.di_st};
   always_comb begin
      if (q.sf_src == 5'h00 || q.sf_src > 5'h10) begin
         sf_open = (fmax < pocsf_pkg::LOW_LIM);
      end else begin
         sf_open = in_all[4'(q.sf_src - 5'h01)];
      end
   end
   assign sf_over = fmax > q.sf_start;
   assign sf_under = 24'(fmax) * 24'(pocsf_pkg::RR_DEN)
      < 24'(q.sf_start) * 24'(pocsf_pkg::RR_NUM);
   assign dead_ms = 24'(q.sf_dead) * 24'(pocsf_pkg::MS_PER_STEP);
   assign win_ms = 24'(q.sf_win) * 24'(pocsf_pkg::MS_PER_STEP);
   assign clr = (reg_wr_in && reg_addr_in == pocsf_pkg::OFS_IRQ_CLR) ? reg_wdata_in[6:0] : 7'h00;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      d = q;
      ev = 7'h00;
      if (enable_in) begin
         d.rdata = 32'h0000_0000;
         d.di_s0 = digital_input_in;
         d.di_s1 = q.di_s0;
         d.di_s2 = q.di_s1;
         d.di_st = (q.di_st & (q.di_s1 ^ q.di_s2)) | (q.di_s2 & ~(q.di_s1 ^ q.di_s2));
         d.tick_cnt = tick ? 16'h0000 : q.tick_cnt + 16'h0001;
         for (int i = 0; i < pocsf_pkg::N_STG; i++) begin
            if (s_under[i]) begin
               d.st_start_o[i] = 1'b0;
               d.st_tmr[i] = 32'h0000_0000;
            end else if (s_over[i]) begin
               d.st_start_o[i] = 1'b1;
            end
            if (d.st_start_o[i] && tick && q.st_tmr[i] < s_tgt[i]) begin
               d.st_tmr[i] = q.st_tmr[i] + s_inc[i];
            end
            d.st_trip_o[i] = d.st_start_o[i] && (d.st_tmr[i] >= s_tgt[i]);
         end
         case (q.sf_st)
            pocsf_pkg::SF_IDLE: begin
               d.sf_tmr = 24'h000000;
               if (sf_open) begin
                  d.sf_st = pocsf_pkg::SF_DEAD;
               end
            end
            pocsf_pkg::SF_DEAD: begin
               if (!sf_open) begin
                  d.sf_st = pocsf_pkg::SF_IDLE;
                  d.sf_tmr = 24'h000000;
               end else if (q.sf_tmr >= dead_ms) begin
                  d.sf_st = pocsf_pkg::SF_ARMED;
                  d.sf_tmr = 24'h000000;
               end else if (tick) begin
                  d.sf_tmr = q.sf_tmr + 24'h000001;
               end
            end
            pocsf_pkg::SF_ARMED: begin
               if (!sf_open) begin
                  d.sf_st = pocsf_pkg::SF_WIN;
                  d.sf_trip = sf_over && (win_ms != 24'h000000);
               end
            end
            pocsf_pkg::SF_WIN: begin
               if (q.sf_trip) begin
                  if (sf_under) begin
                     d.sf_trip = 1'b0;
                     d.sf_st = pocsf_pkg::SF_IDLE;
                     d.sf_tmr = 24'h000000;
                  end
               end else if (sf_open) begin
                  d.sf_st = pocsf_pkg::SF_DEAD;
                  d.sf_tmr = 24'h000000;
               end else if (q.sf_tmr >= win_ms) begin
                  d.sf_st = pocsf_pkg::SF_IDLE;
                  d.sf_tmr = 24'h000000;
               end else begin
                  d.sf_trip = sf_over;
                  if (tick) begin
                     d.sf_tmr = q.sf_tmr + 24'h000001;
                  end
               end
            end
            default: begin
               d.sf_st = pocsf_pkg::SF_IDLE;
            end
         endcase
         // Rising edges are events; set beats clear
         ev = {d.sf_trip & ~q.sf_trip, d.st_trip_o & ~q.st_trip_o,
               d.st_start_o & ~q.st_start_o};
         d.irq_stat = (q.irq_stat & ~clr) | ev;
         if (reg_wr_in) begin
            case (reg_addr_in)
               pocsf_pkg::OFS_CTRL: begin
                  d.grp = reg_wdata_in[pocsf_pkg::CTRL_GRP_LSB +: 2];
                  d.dep_mode = reg_wdata_in[pocsf_pkg::CTRL_DEP_BIT];
                  d.harm = reg_wdata_in[pocsf_pkg::CTRL_HARM_LSB +: 2];
                  d.stg_en = reg_wdata_in[pocsf_pkg::CTRL_EN_LSB +: 3];
               end
               pocsf_pkg::OFS_IRQ_EN: d.irq_en = reg_wdata_in[6:0];
               pocsf_pkg::OFS_SF_START: d.sf_start = reg_wdata_in[15:0];
               pocsf_pkg::OFS_SF_DEAD: d.sf_dead = reg_wdata_in[15:0];
               pocsf_pkg::OFS_SF_WIN: d.sf_win = reg_wdata_in[15:0];
               pocsf_pkg::OFS_SF_SRC: d.sf_src = reg_wdata_in[4:0];
               default: begin
                  if (reg_addr_in[pocsf_pkg::STG_BASE_BIT] && wst != 2'h3) begin
                     if (reg_addr_in[pocsf_pkg::STG_DLY_BIT]) begin
                        d.st_delay[wst][wgp] = reg_wdata_in[19:0];
                     end else begin
                        d.st_start[wst][wgp] = reg_wdata_in[15:0];
                     end
                  end
               end
            endcase
         end
         if (reg_rd_in) begin
            case (reg_addr_in)
               pocsf_pkg::OFS_CTRL: d.rdata = 32'({q.stg_en, q.harm, q.dep_mode, q.grp});
               pocsf_pkg::OFS_STAT: d.rdata = 32'({sf_open, q.sf_st, q.sf_trip,
                                                   q.st_trip_o, q.st_start_o});
               pocsf_pkg::OFS_IRQ_STAT: d.rdata = 32'(q.irq_stat);
               pocsf_pkg::OFS_IRQ_EN: d.rdata = 32'(q.irq_en);
               pocsf_pkg::OFS_SF_START: d.rdata = 32'(q.sf_start);
               pocsf_pkg::OFS_SF_DEAD: d.rdata = 32'(q.sf_dead);
               pocsf_pkg::OFS_SF_WIN: d.rdata = 32'(q.sf_win);
               pocsf_pkg::OFS_SF_SRC: d.rdata = 32'(q.sf_src);
               default: begin
                  if (reg_addr_in[pocsf_pkg::STG_BASE_BIT] && wst != 2'h3) begin
                     if (reg_addr_in[pocsf_pkg::STG_DLY_BIT]) begin
                        d.rdata = 32'(q.st_delay[wst][wgp]);
                     end else begin
                        d.rdata = 32'(q.st_start[wst][wgp]);
                     end
                  end
               end
            endcase
         end
         d.irq = |(d.irq_stat & d.irq_en);
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q <= '0;
         q.st_start <= {(pocsf_pkg::N_STG * pocsf_pkg::N_GRP){pocsf_pkg::RST_ST_START}};
         q.stg_en <= pocsf_pkg::RST_EN;
         q.sf_start <= pocsf_pkg::RST_SF_START;
         q.sf_win <= pocsf_pkg::RST_SF_WIN;
         q.sf_st <= pocsf_pkg::SF_IDLE;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata_out = q.rdata;
   assign stage_start_out = q.st_start_o;
   assign stage_trip_out = q.st_trip_o;
   assign switch_on_fault_trip_out = q.sf_trip;
   assign irq_out = q.irq;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);

   sf_open_a: assert property ($rose(q.sf_trip) |-> $past(q.sf_st) inside
      {pocsf_pkg::SF_ARMED, pocsf_pkg::SF_WIN}) else $error("trip without open breaker");
   sf_fast_a: assert property (enable_in && q.sf_st == pocsf_pkg::SF_ARMED
      && !sf_open && sf_over && win_ms != 24'h000000 |=> q.sf_trip)
      else $error("switch-on trip late");
   dead_arm_a: assert property (q.sf_st == pocsf_pkg::SF_ARMED
      && $past(q.sf_st) == pocsf_pkg::SF_DEAD |-> $past(q.sf_tmr) >= $past(dead_ms))
      else $error("armed before dead time");
   win_trip_a: assert property ($rose(q.sf_trip) |->
      $past(q.sf_st) == pocsf_pkg::SF_ARMED || $past(q.sf_tmr) < $past(win_ms))
      else $error("trip after window");
   win_end_a: assert property (enable_in && q.sf_st == pocsf_pkg::SF_WIN
      && !q.sf_trip && !sf_open && q.sf_tmr >= win_ms |=> q.sf_st == pocsf_pkg::SF_IDLE
      ##1 !q.sf_trip) else $error("window did not disarm");
   low_open_a: assert property (enable_in && q.sf_src == 5'h00
      && q.sf_st == pocsf_pkg::SF_IDLE && fmax < pocsf_pkg::LOW_LIM
      |=> q.sf_st == pocsf_pkg::SF_DEAD) else $error("low current not seen open");
   st_start_a: assert property (enable_in && s_over[1] && !s_under[1]
      |=> q.st_start_o[1]) else $error("stage start missing");
   st_drop_a: assert property (enable_in && s_under[0]
      |=> !q.st_start_o[0] && !q.st_trip_o[0] && q.st_tmr[0] == 32'h0)
      else $error("stage did not reset");
   inst_trip_a: assert property (enable_in && s_over[2] && !s_under[2]
      && s_tgt[2] == 32'h0 |=> q.st_trip_o[2]) else $error("not instantaneous");
   dep_acc_a: assert property (enable_in && tick && q.dep_mode && q.st_start_o[0]
      && !s_under[0] && q.st_tmr[0] < s_tgt[0]
      |=> q.st_tmr[0] == $past(q.st_tmr[0]) + 32'($past(s_cur[0])))
      else $error("dependent delay step wrong");
   sat_a: assert property (fmax <= pocsf_pkg::SAT_LIM && rmax <= pocsf_pkg::SAT_LIM)
      else $error("current not saturated");

   sf_trip_c: cover property ($rose(q.sf_trip));
   stage_trip_c: cover property ($rose(q.st_trip_o[0]) && q.dep_mode);
   win_expire_c: cover property (q.sf_st == pocsf_pkg::SF_WIN ##1 q.sf_st == pocsf_pkg::SF_IDLE);
   irq_c: cover property ($rose(q.irq));
endmodule
`default_nettype wire

// ==== testbench/pocsf_front.sv ====
`timescale 1ns/1ps
`default_nettype none
module pocsf_front (
   input wire logic clock_in, // Relay clock
   input wire logic [47:0] fund_set_in, // Fundamental per phase, line side
   input wire logic [47:0] rms_set_in, // True RMS per phase, line side
   output logic [47:0] fund_out, // Measured fundamental
   output logic [47:0] rms_out // Measured RMS
);
   // ----
   // Measurement refresh
   // ----
   // One cycle of filter latency, no smoothing
   always_ff @(posedge clock_in) begin
      fund_out <= fund_set_in;
      rms_out <= rms_set_in;
   end
endmodule
`default_nettype wire

// ==== testbench/pocsf_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module pocsf_top_tb;
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [47:0] fset = '0;
   logic [47:0] rset = '0;
   logic [47:0] fund;
   logic [47:0] rms;
   logic [7:0] di = 8'h00;
   logic [7:0] vi = 8'h00;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic [2:0] st_start;
   logic [2:0] st_trip;
   logic sf_trip;
   logic irq;
   int mismatches = 0;
   int total_checks = 0;
   int stv[3] = '{32'h64, 32'hC8, 32'h12C};
   logic [2:0] prev = 3'h0;
   logic [7:0] ra[8] = '{8'h00, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h10, 8'h80, 8'h84};
   logic [31:0] rv[8] = '{32'hE0, 32'h64, 32'h0, 32'hA, 32'h0, 32'h0, 32'h64, 32'h0};
   always #50 clock_in = ~clock_in;
   pocsf_front i_front (.clock_in(clock_in), .fund_set_in(fset), .rms_set_in(rset),
      .fund_out(fund), .rms_out(rms));
   pocsf_top #(.TICK_CYCLES(10)) i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .enable_in(1'b1), .fund_l1_in(fund[15:0]), .fund_l2_in(fund[31:16]),
      .fund_l3_in(fund[47:32]), .rms_l1_in(rms[15:0]), .rms_l2_in(rms[31:16]),
      .rms_l3_in(rms[47:32]), .digital_input_in(di), .virtual_input_in(vi),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .stage_start_out(st_start), .stage_trip_out(st_trip),
      .switch_on_fault_trip_out(sf_trip), .irq_out(irq));
   // ----
   // Tasks
   // ----
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s exp %h got %h", what, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock_in);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock_in);
      rd <= 1'b0;
      #1;
      chk("reg", e, rdata);
   endtask
   task automatic set_all(input logic [15:0] f, input logic [15:0] r);
      @(posedge clock_in);
      fset <= {3{f}};
      rset <= {3{r}};
   endtask
   task automatic stage_cmp();
      int mx;
      logic [2:0] e;
      mx = 0;
      for (int p = 0; p < 3; p++) begin
         if (int'(fset[p*16 +: 16]) > mx) begin
            mx = int'(fset[p*16 +: 16]);
         end
      end
      for (int i = 0; i < 3; i++) begin
         e[i] = (mx * int'(pocsf_pkg::RR_DEN) >= stv[i] * int'(pocsf_pkg::RR_NUM)) ?
            (prev[i] | (mx > stv[i])) : 1'b0;
      end
      prev = e;
      chk("start", 32'(e), 32'(st_start));
      chk("trip", 32'(e), 32'(st_trip));
   endtask
   task automatic sf_try(input int open_c, input int mid_c, input logic e);
      set_all(16'h32, 16'h32);
      cyc(1100);
      set_all(16'h0, 16'h0);
      cyc(open_c);
      set_all(16'h32, 16'h32);
      cyc(mid_c);
      set_all(16'h96, 16'h96);
      cyc(4);
      chk("sf_trip", 32'(e), 32'(sf_trip));
      set_all(16'h0, 16'h0);
      cyc(4);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ----
   // Sequence
   // ----
   initial begin
      cyc(30000);
      mismatches++;
      conclude();
   end
   initial begin
      int v;
      void'($urandom(32'hFA75B68C));
      repeat (12) @(posedge clock_in);
      rst_n_in <= 1'b1;
      foreach (ra[i]) rreg(ra[i], rv[i]);
      cyc(1);
      chk("rdata_idle", 32'h0, rdata);
      wreg(8'h44, 32'h5A);
      rreg(8'h44, 32'h0);
      wreg(8'hA0, 32'hC8);
      wreg(8'hC0, 32'h12C);
      for (int k = 0; k < 40; k++) begin
         @(posedge clock_in);
         for (int p = 0; p < 3; p++) begin
            v = $urandom_range(399);
            fset[p*16 +: 16] <= v[15:0];
            rset[p*16 +: 16] <= v[15:0];
         end
         cyc(3);
         stage_cmp();
      end
      set_all(16'h0, 16'h0);
      wreg(8'hC4, 32'h1);
      set_all(16'h190, 16'h190);
      cyc(83);
      chk("trip2_early", 32'h0, 32'(st_trip[2]));
      cyc(40);
      chk("trip2", 32'h1, 32'(st_trip[2]));
      set_all(16'h124, 16'h124);
      cyc(3);
      chk("start2_band", 32'h1, 32'(st_start[2]));
      set_all(16'h122, 16'h122);
      cyc(3);
      chk("stage2_clear", 32'h0, 32'({st_start[2], st_trip[2]}));
      set_all(16'h0, 16'h0);
      wreg(8'hA4, 32'h1);
      wreg(8'h00, 32'hF0);
      set_all(16'h96, 16'hFA);
      cyc(3);
      chk("start1_rms", 32'h1, 32'(st_start[1]));
      cyc(122);
      chk("trip1_early", 32'h0, 32'(st_trip[1]));
      cyc(50);
      chk("trip1", 32'h1, 32'(st_trip[1]));
      wreg(8'h00, 32'hE0);
      cyc(3);
      chk("start1_fund", 32'h0, 32'(st_start[1]));
      set_all(16'h0, 16'h0);
      wreg(8'h88, 32'h1F4);
      wreg(8'h00, 32'hE1);
      set_all(16'h12C, 16'h12C);
      cyc(3);
      chk("start0_grp1", 32'h0, 32'(st_start[0]));
      wreg(8'h00, 32'hE0);
      cyc(3);
      chk("start0_grp0", 32'h1, 32'(st_start[0]));
      set_all(16'h0, 16'h0);
      wreg(8'h84, 32'h1);
      wreg(8'h00, 32'hE4);
      set_all(16'hC8, 16'hC8);
      cyc(33);
      chk("dep_early", 32'h0, 32'(st_trip[0]));
      cyc(40);
      chk("dep_trip", 32'h1, 32'(st_trip[0]));
      set_all(16'h0, 16'h0);
      wreg(8'h80, 32'h1388);
      set_all(16'hFFFF, 16'hFFFF);
      cyc(50);
      chk("dep_sat", 32'h0, 32'(st_trip[1:0]));
      cyc(80);
      chk("dep_sat_hold", 32'h0, 32'({st_start[0], st_trip[0]}));
      set_all(16'h0, 16'h0);
      wreg(8'h80, 32'h64);
      wreg(8'h84, 32'h0);
      wreg(8'h00, 32'hE2);
      wreg(8'h18, 32'h1);
      wreg(8'h10, 32'h40);
      wreg(8'h0C, 32'h7F);
      sf_try(200, 2, 1'b1);
      chk("irq", 32'h1, 32'(irq));
      rreg(8'h08, 32'h7F);
      wreg(8'h10, 32'h0);
      cyc(2);
      chk("irq_masked", 32'h0, 32'(irq));
      wreg(8'h10, 32'h40);
      wreg(8'h0C, 32'h7F);
      cyc(2);
      chk("irq_clear", 32'h0, 32'(irq));
      rreg(8'h08, 32'h0);
      sf_try(50, 2, 1'b0);
      sf_try(200, 1100, 1'b0);
      sf_try(200, 500, 1'b1);
      set_all(16'h32, 16'h32);
      cyc(1100);
      for (int s = 0; s < 2; s++) begin
         wreg(8'h20, (s == 1) ? 32'h9 : 32'h1);
         set_all(16'h96, 16'h96);
         cyc(4);
         chk("sf_no_open", 32'h0, 32'(sf_trip));
         set_all(16'h32, 16'h32);
         @(posedge clock_in);
         di <= (s == 1) ? 8'h00 : 8'h01;
         vi <= (s == 1) ? 8'h01 : 8'h00;
         cyc(200);
         @(posedge clock_in);
         di <= 8'h00;
         vi <= 8'h00;
         cyc(6);
         set_all(16'h96, 16'h96);
         cyc(4);
         chk("sf_input", 32'h1, 32'(sf_trip));
         set_all(16'h32, 16'h32);
         cyc(4);
      end
      conclude();
   end
endmodule
`default_nettype wire
